/* File: design/rmw_slave.sv */
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`include "rmw_defines.svh"

// Overview of operation
// - RMW is one read then one write
// - Slave acks read half with valid data
// - Slave drops ack whenever stb is low
// - Slave may stall ack in write half
// - Slave captures write data on ack
// - RMW support may be switched off
// - Big endian: most significant at lower address
// - Little endian: most significant at higher address
// - Big endian 64-bit: unit 0 on top lanes
// - Little endian 64-bit: unit 0 bottom lanes
// - Units under granularity are not transferable
// - Wide operands split into port-width cycles
// - Port width is 8, 16, 32, 64
// - Granularity and operand size from that set
// - Unknown operand size equals granularity
// - Width equal granularity: orderings identical
// - Pieces go low address to high
module rmw_slave
    import rmw_pkg::*;
#(
    parameter int PORT_W = 32,
    parameter int GRAN_W = 8,
    parameter int OPER_W = 0,
    parameter int WAIT_W = 1
)
(
    input wire logic clk_i,
    input wire logic nrst_i,
    // Port A: register and semaphore master
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Port B: second master competing for the shared word
    input wire logic b_cyc_i,
    input wire logic b_stb_i,
    input wire logic b_we_i,
    input wire logic [2:0] b_adr_i,
    input wire logic [PORT_W/8-1:0] b_sel_i,
    input wire logic [PORT_W-1:0] b_dat_i,
    output logic [PORT_W-1:0] b_dat_o,
    output logic b_ack_o,
    output logic b_err_o
);
    // Port width, granularity and operand size
    // Unknown operand size (0) falls back to granularity
    localparam int OPS_W = (OPER_W == 0) ? GRAN_W : OPER_W;
    localparam int NPIECE = 64 / PORT_W;
    localparam int GSEL = GRAN_W / 8;

    initial
    begin
        if (!(PORT_W inside {8, 16, 32, 64}))
            $error("port width must be 8, 16, 32 or 64");
        if (!(GRAN_W inside {8, 16, 32, 64}) || GRAN_W > PORT_W)
            $error("granularity must be 8..64 and fit the port");
        if (!(OPS_W inside {8, 16, 32, 64}) || OPS_W < GRAN_W)
            $error("operand size must be 8..64, not below granularity");
        if (WAIT_W < 0 || WAIT_W > 15)
            $error("write wait states must be 0..15");
    end

    typedef struct packed {
        logic [1:0] ctrl;
        logic [63:0] mem;
        rmw_phase_t phase;
        logic ack_a;
        logic ack_b;
        logic err_b;
        logic [31:0] rd_a;
        logic [PORT_W-1:0] rd_b;
        logic [2:0] lock_adr;
        logic [3:0] wait_cnt;
        logic [`RMW_STAT_CNT_W-1:0] rmw_cnt;
    } rmw_state_t;

    rmw_state_t s_q;
    rmw_state_t s_d;

    logic big;
    logic [PORT_W-1:0] lane_rd;
    logic sel_ok;
    logic locked;
    logic [63:0] wr_mask;

    // Width equal to granularity: both orderings coincide
    assign big = (PORT_W == GRAN_W) ? 1'b0 : s_q.ctrl[`RMW_CTRL_BIG_BIT];
    assign locked = (s_q.phase != RMW_IDLE);
    assign ack_o = s_q.ack_a;
    assign dat_o = s_q.rd_a;
    assign b_ack_o = s_q.ack_b;
    assign b_err_o = s_q.err_b;
    assign b_dat_o = s_q.rd_b;

    // Piece order: lower address first
    rmw_lane #(.PORT_W(PORT_W)) u_lane
    (
        .operand_i(s_q.mem),
        .piece_i(b_adr_i),
        .big_i(big),
        .lane_o(lane_rd)
    );

    // Byte selects must cover whole granules
    function automatic logic gran_ok(input logic [PORT_W/8-1:0] sel);
        logic ok;
        ok = (sel != '0);
        for (int g = 0; g < PORT_W / 8; g += GSEL)
        begin
            if (sel[g +: GSEL] != '0 && sel[g +: GSEL] != '1)
                ok = 1'b0;
        end
        gran_ok = ok;
    endfunction

    assign sel_ok = gran_ok(b_sel_i);

    // Lane index of a piece inside the 64-bit word
    function automatic int piece_lane(input logic [2:0] adr,
        input logic big_ord);
        int pc;
        pc = int'(adr) % NPIECE;
        if (big_ord)
        begin
            pc = NPIECE - 1 - pc;
        end
        piece_lane = pc;
    endfunction

    // Byte-lane mask of one port-width piece
    function automatic logic [63:0] piece_mask(input int lane,
        input logic [PORT_W/8-1:0] sel);
        logic [63:0] m;
        m = '0;
        for (int i = 0; i < PORT_W / 8; i++)
        begin
            if (sel[i])
            begin
                m[lane*PORT_W + i*8 +: 8] = 8'hFF;
            end
        end
        piece_mask = m;
    endfunction

    // Merge a port-width piece into the word under a mask
    function automatic logic [63:0] merge(input logic [63:0] word,
        input logic [PORT_W-1:0] dat, input logic [63:0] mask);
        merge = (word & ~mask) | ({NPIECE{dat}} & mask);
    endfunction

    // Byte-enable update of one 32-bit half of the word
    function automatic logic [31:0] half_wr(input logic [31:0] old,
        input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        half_wr = r;
    endfunction

    always_comb
    begin
        s_d = s_q;
        wr_mask = piece_mask(piece_lane(b_adr_i, big), b_sel_i);

        // Port A register access, single cycle
        s_d.ack_a = 1'b0;
        if (cyc_i && stb_i && !s_q.ack_a)
        begin
            s_d.ack_a = 1'b1;
            s_d.rd_a = '0;
            unique case (adr_i)
                `RMW_OFS_CTRL:
                begin
                    s_d.rd_a[1:0] = s_q.ctrl;
                    if (we_i && sel_i[0])
                        s_d.ctrl = dat_i[1:0];
                end
                `RMW_OFS_STAT:
                begin
                    s_d.rd_a[`RMW_STAT_LOCK_BIT] = locked;
                    s_d.rd_a[`RMW_STAT_RMW_BIT] = (s_q.phase == RMW_GAP);
                    s_d.rd_a[`RMW_STAT_CNT_LSB +: `RMW_STAT_CNT_W] =
                        s_q.rmw_cnt;
                end
                `RMW_OFS_OPHI:
                begin
                    s_d.rd_a = s_q.mem[63:32];
                    if (we_i && !locked)
                        s_d.mem[63:32] = half_wr(s_q.mem[63:32], dat_i, sel_i);
                end
                `RMW_OFS_OPLO:
                begin
                    s_d.rd_a = s_q.mem[31:0];
                    if (we_i && !locked)
                        s_d.mem[31:0] = half_wr(s_q.mem[31:0], dat_i, sel_i);
                end
                default:
                    s_d.rd_a = '0;
            endcase
        end

        // Port B: ack drops whenever stb is low
        s_d.ack_b = 1'b0;
        s_d.err_b = 1'b0;
        unique case (s_q.phase)
            RMW_IDLE:
            begin
                s_d.wait_cnt = '0;
                // Read half: we low with stb and cyc
                if (b_cyc_i && b_stb_i && !s_q.ack_b && !s_q.err_b)
                begin
                    if (!sel_ok)
                        s_d.err_b = 1'b1;
                    else if (!b_we_i)
                    begin
                        s_d.ack_b = 1'b1;
                        s_d.rd_b = lane_rd;
                        s_d.lock_adr = b_adr_i;
                        if (s_q.ctrl[`RMW_CTRL_RMW_BIT])
                            s_d.phase = RMW_READ;
                    end
                    else
                    begin
                        s_d.ack_b = 1'b1;
                        s_d.mem = merge(s_q.mem, b_dat_i, wr_mask);
                    end
                end
            end
            RMW_READ:
            begin
                // Read acked; on to gap while cyc held, else back to idle
                if (!b_cyc_i)
                    s_d.phase = RMW_IDLE;
                else
                    s_d.phase = RMW_GAP;
            end
            RMW_GAP:
            begin
                // Cyc held across halves keeps lock
                if (!b_cyc_i)
                    s_d.phase = RMW_IDLE;
                else if (b_stb_i && b_we_i)
                begin
                    if (b_adr_i != s_q.lock_adr || !sel_ok)
                    begin
                        s_d.err_b = 1'b1;
                        s_d.phase = RMW_IDLE;
                    end
                    else
                        s_d.phase = RMW_WRITE;
                end
            end
            RMW_WRITE:
            begin
                if (!b_cyc_i || !b_stb_i)
                    s_d.phase = b_cyc_i ? RMW_GAP : RMW_IDLE;
                else if (s_q.wait_cnt < 4'(WAIT_W))
                    s_d.wait_cnt = s_q.wait_cnt + 4'h1;
                else
                begin
                    // Capture write data on ack, end lock
                    s_d.ack_b = 1'b1;
                    s_d.mem = merge(s_q.mem, b_dat_i, wr_mask);
                    s_d.rmw_cnt = s_q.rmw_cnt + 16'h0001;
                    s_d.phase = RMW_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_q.ctrl <= `RMW_CTRL_RST;
            s_q.mem <= `RMW_MEM_RST;
            s_q.phase <= RMW_IDLE;
            s_q.ack_a <= 1'b0;
            s_q.ack_b <= 1'b0;
            s_q.err_b <= 1'b0;
            s_q.rd_a <= 32'h00000000;
            s_q.rd_b <= '0;
            s_q.lock_adr <= 3'h0;
            s_q.wait_cnt <= 4'h0;
            s_q.rmw_cnt <= 16'h0000;
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule

/* File: inc/rmw_defines.svh */
`ifndef RMW_DEFINES_SVH
`define RMW_DEFINES_SVH

// Register byte offsets
`define RMW_OFS_CTRL 8'h00
`define RMW_OFS_STAT 8'h04
`define RMW_OFS_OPHI 8'h08
`define RMW_OFS_OPLO 8'h0C

// Control fields
`define RMW_CTRL_BIG_BIT 0
`define RMW_CTRL_RMW_BIT 1
`define RMW_CTRL_RST 2'h0

// Status fields
`define RMW_STAT_LOCK_BIT 0
`define RMW_STAT_RMW_BIT 1
`define RMW_STAT_CNT_LSB 8
`define RMW_STAT_CNT_W 16

// Reset values
`define RMW_MEM_RST 64'h0000000000000000

`endif

/* File: inc/rmw_pkg.sv */
package rmw_pkg;

    typedef enum logic [1:0]
    {
        RMW_IDLE = 2'b00,
        RMW_READ = 2'b01,
        RMW_GAP = 2'b10,
        RMW_WRITE = 2'b11
    } rmw_phase_t;

endpackage

/* File: design/rmw_lane.sv */
`timescale 1ns/10ps
`include "rmw_defines.svh"

// Maps a 64-bit operand onto one port-width bus cycle
module rmw_lane
    import rmw_pkg::*;
#(
    parameter int PORT_W = 32
)
(
    input wire logic [63:0] operand_i,
    input wire logic [2:0] piece_i,
    input wire logic big_i,
    output logic [PORT_W-1:0] lane_o
);
    localparam int NPIECE = 64 / PORT_W;

    function automatic logic [PORT_W-1:0] pick(
        input logic [63:0] op,
        input logic [2:0] piece,
        input logic big
    );
        int idx;
        idx = int'(piece) % NPIECE;
        if (big)
        begin
            idx = NPIECE - 1 - idx;
        end
        pick = op[idx*PORT_W +: PORT_W];
    endfunction

    // Big endian: piece 0 holds the most significant part
    // Little endian: piece 0 holds the least significant part
    always_comb
    begin
        lane_o = pick(operand_i, piece_i, big_i);
    end
endmodule

/* File: verification/rmw_slave_properties.sv */
`timescale 1ns/10ps
module rmw_slave_chk
#(
    parameter int PORT_W = 32
)
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic b_cyc_i,
    input wire logic b_stb_i,
    input wire logic b_we_i,
    input wire logic [PORT_W/8-1:0] b_sel_i,
    input wire logic b_ack_o,
    input wire logic b_err_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    AST_A_ACK: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o) else $error("A ack late");
    AST_A_NOSTB: assert property (
        !stb_i |=> !ack_o) else $error("A ack without stb");
    AST_B_NOSTB: assert property (
        !b_stb_i |=> !b_ack_o) else $error("B ack without stb");
    AST_B_BOUND: assert property (
        b_cyc_i && b_stb_i |-> ##[0:4] (b_ack_o || b_err_o))
        else $error("B answer late");
    AST_B_HELD: assert property (
        b_ack_o |-> b_cyc_i && b_stb_i) else $error("B ack off cycle");
    AST_B_PULSE: assert property (
        b_err_o |=> !b_err_o && !b_ack_o) else $error("B err held");
    AST_B_EXCL: assert property (
        !(b_ack_o && b_err_o)) else $error("B ack and err");
    AST_B_SEL: assert property (
        $rose(b_stb_i) && b_cyc_i && b_sel_i == '0 |=> b_err_o && !b_ack_o)
        else $error("B zero sel taken");
    AST_B_READ: assert property (
        $rose(b_stb_i) && b_cyc_i && !b_we_i && b_sel_i != '0 |=> b_ack_o)
        else $error("B read ack late");
endmodule

bind rmw_slave rmw_slave_chk #(.PORT_W(PORT_W)) rmw_slave_chk_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .b_cyc_i(b_cyc_i), .b_stb_i(b_stb_i), .b_we_i(b_we_i),
    .b_sel_i(b_sel_i), .b_ack_o(b_ack_o), .b_err_o(b_err_o));

/* File: verification/rmw_master_model.sv */
`timescale 1ns/10ps
module rmw_master_model
(
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic err_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [2:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial
    begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end
    // One transfer; cyc stays up so a write half may follow
    task automatic req(input logic we, input logic [2:0] adr,
        input logic [3:0] sel, input logic [31:0] dat, output logic to);
        int n;
        @(posedge clk_i);
        cyc_o <= 1'h1;
        stb_o <= 1'h1;
        we_o <= we;
        adr_o <= adr;
        sel_o <= sel;
        dat_o <= dat;
        n = 0;
        @(posedge clk_i);
        while (!(ack_i || err_i) && n < 50)
        begin
            @(posedge clk_i);
            n++;
        end
        to = n >= 50;
        stb_o <= 1'h0;
        dat_o <= ~dat;
    endtask
    task automatic drop();
        @(posedge clk_i);
        cyc_o <= 1'h0;
    endtask
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic clk_i, nrst_i, cyc_i, stb_i, we_i, ack_o, b_cyc_i, b_stb_i;
    logic b_we_i, b_ack_o, b_err_o, to;
    logic [7:0] adr_i;
    logic [3:0] sel_i, b_sel_i;
    logic [2:0] b_adr_i;
    logic [31:0] dat_i, dat_o, b_dat_i, b_dat_o, v1, v2, v3;
    logic [31:0] q[$];
    int seed = 32'h43BE6A33;
    int n_fail = 0;
    int checked = 0;
    always #5 clk_i = ~clk_i;
    rmw_slave rmw_slave_inst (.clk_i(clk_i), .nrst_i(nrst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .b_cyc_i(b_cyc_i),
        .b_stb_i(b_stb_i), .b_we_i(b_we_i), .b_adr_i(b_adr_i),
        .b_sel_i(b_sel_i), .b_dat_i(b_dat_i), .b_dat_o(b_dat_o),
        .b_ack_o(b_ack_o), .b_err_o(b_err_o));
    rmw_master_model rmw_master_model_inst (.clk_i(clk_i), .ack_i(b_ack_o),
        .err_i(b_err_o), .cyc_o(b_cyc_i), .stb_o(b_stb_i), .we_o(b_we_i),
        .adr_o(b_adr_i), .sel_o(b_sel_i), .dat_o(b_dat_i));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t read %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (n_fail == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic lim(input logic t);
        if (t)
        begin
            n_fail++;
            results();
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] adr,
        input logic [31:0] dat);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= we;
        adr_i <= adr;
        sel_i <= 4'hF;
        dat_i <= dat;
        n = 0;
        @(posedge clk_i);
        while (!ack_o && n < 50)
        begin
            @(posedge clk_i);
            n++;
        end
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        dat_i <= ~dat;
        lim(n >= 50);
    endtask
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        q.push_back(exp);
        bus(1'h0, adr, 32'h0);
    endtask
    task automatic breq(input logic we, input logic [2:0] adr,
        input logic [3:0] sel, input logic [31:0] dat, input logic keep);
        rmw_master_model_inst.req(we, adr, sel, dat, to);
        lim(to);
        if (!keep)
            rmw_master_model_inst.drop();
    endtask
    always @(posedge clk_i)
    begin
        if (ack_o && !we_i)
            check(dat_o, q.pop_front());
        if (b_ack_o && !b_we_i)
            check(b_dat_o, q.pop_front());
        if (b_err_o)
            check({30'h0, b_ack_o, b_err_o}, q.pop_front());
    end
    initial
    begin
        {clk_i, nrst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'h1;
        v1 = $random(seed);
        v2 = $random(seed);
        v3 = $random(seed);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        bus(1'h1, 8'h08, v1);
        bus(1'h1, 8'h0C, v2);
        bus(1'h1, 8'h10, v3);
        rd(8'h08, v1);
        rd(8'h10, 32'h0);
        for (int e = 0; e < 2; e++)
        begin
            bus(1'h1, 8'h00, 32'(e));
            for (int p = 0; p < 2; p++)
            begin
                q.push_back((p != e) ? v1 : v2);
                breq(1'h0, 3'(p), 4'hF, 32'h0, 1'h0);
            end
        end
        bus(1'h1, 8'h00, 32'h3);
        q.push_back(v2);
        breq(1'h0, 3'h1, 4'hF, 32'h0, 1'h1);
        bus(1'h1, 8'h0C, v1);
        bus(1'h1, 8'h08, v3);
        rd(8'h04, 32'h3);
        rd(8'h08, v1);
        breq(1'h1, 3'h1, 4'hF, v3, 1'h0);
        rd(8'h0C, v3);
        rd(8'h04, 32'h100);
        q.push_back(v1);
        breq(1'h0, 3'h0, 4'hF, 32'h0, 1'h1);
        q.push_back(32'h1);
        breq(1'h1, 3'h1, 4'hF, v2, 1'h0);
        rd(8'h0C, v3);
        rd(8'h04, 32'h100);
        q.push_back(32'h1);
        breq(1'h0, 3'h0, 4'h0, 32'h0, 1'h0);
        repeat (4) @(posedge clk_i);
        if (q.size() != 0)
            n_fail++;
        results();
    end
endmodule
